// ---- hdl/cep_pkg.sv ----
// Constants and types shared by the configuration store controller
package cep_pkg;
    // Key values for the programming key register
    localparam logic [7:0] KEY_RESET = 8'h00;
    localparam logic [7:0] KEY_UNLOCK = 8'h41;
    localparam logic [7:0] KEY_PREREAD = 8'h62;
    // Register offsets on the serial port, and the value read from unmapped ones
    localparam logic [7:0] REG_CFG_FIRST = 8'h01;
    localparam logic [7:0] REG_CFG_LAST = 8'h0a;
    localparam logic [7:0] REG_NV_PROGRAM_KEY = 8'h0b;
    localparam logic [7:0] RDATA_UNMAPPED = 8'h00;
    // Store layout: row 0 holds column parity, rows 1 to 10 hold settings
    localparam logic [3:0] ROW_PARITY = 4'h0;
    localparam logic [3:0] ROW_FIRST = 4'h1;
    localparam logic [3:0] ROW_LAST = 4'ha;
    localparam int ROWS = 16;
    // Serial bit counting
    localparam logic [2:0] BIT_FIRST = 3'h0;
    localparam logic [2:0] BIT_LAST = 3'h7;
    // Slave address, arbitrary default
    localparam logic [6:0] DEV_ADDR_DEF = 7'h10;

    typedef enum logic [3:0] {
        SER_IDLE,
        SER_ADDR,
        SER_ADDR_ACK,
        SER_PTR,
        SER_PTR_ACK,
        SER_WDATA,
        SER_WDATA_ACK,
        SER_RDATA,
        SER_RDATA_ACK
    } cep_ser_st_t;

    typedef enum logic [2:0] {
        SEQ_LOAD_REQ,
        SEQ_LOAD_CAP,
        SEQ_IDLE,
        SEQ_WRITE,
        SEQ_PARITY
    } cep_seq_st_t;
endpackage

// ---- hdl/cep_nv_mem.sv ----
// Nonvolatile row store with registered read and column parity check
`timescale 1ns/1ps
module cep_nv_mem (
    // Clock
    input wire logic clk_i,
    // Write port
    input wire logic wr_en_i,
    input wire logic [3:0] wr_addr_i,
    input wire logic [7:0] wr_data_i,
    // Read port
    input wire logic [3:0] rd_addr_i,
    output logic [7:0] rd_data_o,
    // Column parity mismatch
    output logic par_err_o
);
    // No reset: contents must survive a reset like a real store
    logic [7:0] mem_r [cep_pkg::ROWS];
    logic [7:0] col_nxt;

    always_ff @(posedge clk_i) begin
        if (wr_en_i) begin
            mem_r[wr_addr_i] <= wr_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        rd_data_o <= mem_r[rd_addr_i];
    end

    // One check bit per column over the parity row and the setting rows
    always_comb begin
        col_nxt = mem_r[cep_pkg::ROW_PARITY];
        for (int i = 1; i <= int'(cep_pkg::ROW_LAST); i++) begin
            col_nxt = col_nxt ^ mem_r[i];
        end
    end

    always_ff @(posedge clk_i) begin
        par_err_o <= |col_nxt;
    end
endmodule

// ---- hdl/cep_ctrl.sv ----
// Serial register port, key lock, commit sequencer and parity fail-safe
`timescale 1ns/1ps
module cep_ctrl #(
    parameter logic [6:0] DEV_ADDR = cep_pkg::DEV_ADDR_DEF
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Serial port
    input wire logic serial_port_select_pin_i,
    input wire logic serial_clock_line_i,
    input wire logic serial_data_line_i,
    output logic serial_data_line_o,
    output logic serial_data_line_oe_o,
    // Commit pin
    input wire logic nv_commit_pin_i,
    // Power path drives
    output logic discharge_fet_drive_o,
    output logic charge_fet_drive_o
);
    logic [7:0] cfg_r [cep_pkg::ROWS];
    logic [7:0] nv_program_key_r;
    cep_pkg::cep_ser_st_t ser_st_r;
    cep_pkg::cep_seq_st_t seq_st_r;
    logic [2:0] bit_cnt_r;
    logic [7:0] shift_r;
    logic [7:0] ptr_r;
    logic [3:0] seq_row_r;
    logic rd_mode_r, scl_q_r, sda_q_r, commit_q_r, idle_q1_r, idle_q2_r;
    logic [7:0] mem_rdata, mem_wdata, rd_src, cfg_par;
    logic [3:0] mem_waddr, mem_raddr;
    logic mem_par_err, mem_we;
    logic scl_rise, scl_fall, bus_start, bus_stop, wr_strobe, commit_go;
    function automatic logic is_cfg(input logic [7:0] a);
        return a >= cep_pkg::REG_CFG_FIRST && a <= cep_pkg::REG_CFG_LAST;
    endfunction

    // Pins are synchronous; the previous sample gives edges
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
            commit_q_r <= 1'b0;
        end else begin
            scl_q_r <= serial_clock_line_i;
            sda_q_r <= serial_data_line_i;
            commit_q_r <= nv_commit_pin_i;
        end
    end

    assign scl_rise = serial_clock_line_i & ~scl_q_r;
    assign scl_fall = ~serial_clock_line_i & scl_q_r;
    assign bus_start = serial_clock_line_i & scl_q_r &
        sda_q_r & ~serial_data_line_i;
    assign bus_stop = serial_clock_line_i & scl_q_r &
        ~sda_q_r & serial_data_line_i;
    assign wr_strobe = (ser_st_r == cep_pkg::SER_WDATA) && scl_rise &&
        (bit_cnt_r == cep_pkg::BIT_LAST) && serial_port_select_pin_i;

    // Read data: settings, stored copy under pre-read, key, else zero
    always_comb begin
        if (ptr_r == cep_pkg::REG_NV_PROGRAM_KEY) begin
            rd_src = nv_program_key_r;
        end else if (is_cfg(ptr_r)) begin
            if (nv_program_key_r == cep_pkg::KEY_PREREAD) begin
                rd_src = mem_rdata;
            end else begin
                rd_src = cfg_r[ptr_r[3:0]];
            end
        end else begin
            rd_src = cep_pkg::RDATA_UNMAPPED;
        end
    end

    // Serial slave; everything idles while the select pin is low
    always_ff @(posedge clk_i) begin
        if (!nrst_i || !serial_port_select_pin_i) begin
            ser_st_r <= cep_pkg::SER_IDLE;
            bit_cnt_r <= cep_pkg::BIT_FIRST;
            shift_r <= 8'h00;
            rd_mode_r <= 1'b0;
            serial_data_line_oe_o <= 1'b0;
        end else if (bus_start) begin
            ser_st_r <= cep_pkg::SER_ADDR;
            bit_cnt_r <= cep_pkg::BIT_FIRST;
            serial_data_line_oe_o <= 1'b0;
        end else if (bus_stop) begin
            ser_st_r <= cep_pkg::SER_IDLE;
            serial_data_line_oe_o <= 1'b0;
        end else begin
            case (ser_st_r)
                cep_pkg::SER_ADDR, cep_pkg::SER_PTR,
                cep_pkg::SER_WDATA: begin
                    if (scl_rise) begin
                        shift_r <= {shift_r[6:0], serial_data_line_i};
                        bit_cnt_r <= bit_cnt_r + 3'h1;
                    end
                    if (scl_rise && bit_cnt_r == cep_pkg::BIT_LAST) begin
                        if (ser_st_r == cep_pkg::SER_ADDR) begin
                            if (shift_r[6:0] == DEV_ADDR) begin
                                ser_st_r <= cep_pkg::SER_ADDR_ACK;
                                rd_mode_r <= serial_data_line_i;
                            end else begin
                                ser_st_r <= cep_pkg::SER_IDLE;
                            end
                        end else if (ser_st_r == cep_pkg::SER_PTR) begin
                            ser_st_r <= cep_pkg::SER_PTR_ACK;
                        end else begin
                            ser_st_r <= cep_pkg::SER_WDATA_ACK;
                        end
                    end
                end
                cep_pkg::SER_ADDR_ACK, cep_pkg::SER_PTR_ACK,
                cep_pkg::SER_WDATA_ACK: begin
                    if (scl_fall) begin
                        if (!serial_data_line_oe_o) begin
                            serial_data_line_oe_o <= 1'b1;
                        end else if (ser_st_r == cep_pkg::SER_ADDR_ACK &&
                            rd_mode_r) begin
                            ser_st_r <= cep_pkg::SER_RDATA;
                            shift_r <= rd_src;
                            serial_data_line_oe_o <= ~rd_src[7];
                        end else begin
                            serial_data_line_oe_o <= 1'b0;
                            ser_st_r <= (ser_st_r == cep_pkg::SER_ADDR_ACK) ?
                                cep_pkg::SER_PTR : cep_pkg::SER_WDATA;
                        end
                    end
                end
                cep_pkg::SER_RDATA: begin
                    if (scl_fall) begin
                        bit_cnt_r <= bit_cnt_r + 3'h1;
                        if (bit_cnt_r == cep_pkg::BIT_LAST) begin
                            ser_st_r <= cep_pkg::SER_RDATA_ACK;
                            serial_data_line_oe_o <= 1'b0;
                        end else begin
                            shift_r <= {shift_r[6:0], 1'b0};
                            serial_data_line_oe_o <= ~shift_r[6];
                        end
                    end
                end
                cep_pkg::SER_RDATA_ACK: begin
                    if (scl_rise) begin
                        // Host NACK ends the read; ACK asks for the next byte
                        ser_st_r <= serial_data_line_i ?
                            cep_pkg::SER_IDLE : cep_pkg::SER_RDATA_ACK;
                        rd_mode_r <= ~serial_data_line_i;
                    end else if (scl_fall && rd_mode_r) begin
                        ser_st_r <= cep_pkg::SER_RDATA;
                        shift_r <= rd_src;
                        serial_data_line_oe_o <= ~rd_src[7];
                    end
                end
                default: begin
                    ser_st_r <= cep_pkg::SER_IDLE;
                end
            endcase
        end
    end
    // Open drain: only ever pulls low
    always_ff @(posedge clk_i) begin
        serial_data_line_o <= 1'b0;
    end

    // Register pointer, auto-incremented after each data byte
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            ptr_r <= 8'h00;
        end else if (ser_st_r == cep_pkg::SER_PTR && scl_rise &&
            bit_cnt_r == cep_pkg::BIT_LAST && serial_port_select_pin_i) begin
            ptr_r <= {shift_r[6:0], serial_data_line_i};
        end else if (wr_strobe || (ser_st_r == cep_pkg::SER_RDATA_ACK &&
            scl_rise && serial_port_select_pin_i)) begin
            ptr_r <= ptr_r + 8'h01;
        end
    end

    // Key register
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            nv_program_key_r <= cep_pkg::KEY_RESET;
        end else if (wr_strobe && ptr_r == cep_pkg::REG_NV_PROGRAM_KEY) begin
            nv_program_key_r <= {shift_r[6:0], serial_data_line_i};
        end
    end

    // Settings: loaded from the store after reset, then written by host
    always_ff @(posedge clk_i) begin
        if (seq_st_r == cep_pkg::SEQ_LOAD_CAP) begin
            cfg_r[seq_row_r] <= mem_rdata;
        end else if (wr_strobe && is_cfg(ptr_r)) begin
            cfg_r[ptr_r[3:0]] <= {shift_r[6:0], serial_data_line_i};
        end
    end

    // Falling edge of a high-then-low commit pulse, honoured only unlocked
    assign commit_go = commit_q_r && !nv_commit_pin_i &&
        nv_program_key_r == cep_pkg::KEY_UNLOCK &&
        seq_st_r == cep_pkg::SEQ_IDLE;

    // Load and commit sequencer, one row per step
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            seq_st_r <= cep_pkg::SEQ_LOAD_REQ;
            seq_row_r <= cep_pkg::ROW_FIRST;
        end else begin
            case (seq_st_r)
                cep_pkg::SEQ_LOAD_REQ: begin
                    seq_st_r <= cep_pkg::SEQ_LOAD_CAP;
                end
                cep_pkg::SEQ_LOAD_CAP: begin
                    if (seq_row_r == cep_pkg::ROW_LAST) begin
                        seq_st_r <= cep_pkg::SEQ_IDLE;
                    end else begin
                        seq_st_r <= cep_pkg::SEQ_LOAD_REQ;
                        seq_row_r <= seq_row_r + 4'h1;
                    end
                end
                cep_pkg::SEQ_IDLE: begin
                    if (commit_go) begin
                        seq_st_r <= cep_pkg::SEQ_WRITE;
                        seq_row_r <= cep_pkg::ROW_FIRST;
                    end
                end
                cep_pkg::SEQ_WRITE: begin
                    if (seq_row_r == cep_pkg::ROW_LAST) begin
                        seq_st_r <= cep_pkg::SEQ_PARITY;
                    end else begin
                        seq_row_r <= seq_row_r + 4'h1;
                    end
                end
                cep_pkg::SEQ_PARITY: begin
                    seq_st_r <= cep_pkg::SEQ_IDLE;
                end
                default: begin
                    seq_st_r <= cep_pkg::SEQ_IDLE;
                end
            endcase
        end
    end

    always_comb begin
        cfg_par = 8'h00;
        for (int i = 1; i <= int'(cep_pkg::ROW_LAST); i++) begin
            cfg_par = cfg_par ^ cfg_r[i];
        end
    end

    assign mem_we = seq_st_r == cep_pkg::SEQ_WRITE ||
        seq_st_r == cep_pkg::SEQ_PARITY;
    assign mem_waddr = (seq_st_r == cep_pkg::SEQ_PARITY) ?
        cep_pkg::ROW_PARITY : seq_row_r;
    assign mem_wdata = (seq_st_r == cep_pkg::SEQ_PARITY) ?
        cfg_par : cfg_r[seq_row_r];
    assign mem_raddr = (seq_st_r == cep_pkg::SEQ_IDLE) ?
        ptr_r[3:0] : seq_row_r;

    cep_nv_mem u_mem (
        .clk_i(clk_i),
        .wr_en_i(mem_we),
        .wr_addr_i(mem_waddr),
        .wr_data_i(mem_wdata),
        .rd_addr_i(mem_raddr),
        .rd_data_o(mem_rdata),
        .par_err_o(mem_par_err)
    );

    // Parity result lags the store by a cycle, so wait two idle cycles
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            idle_q1_r <= 1'b0;
            idle_q2_r <= 1'b0;
        end else begin
            idle_q1_r <= seq_st_r == cep_pkg::SEQ_IDLE;
            idle_q2_r <= idle_q1_r && seq_st_r == cep_pkg::SEQ_IDLE;
        end
    end

    // Drives stay off until a clean check; held during a commit
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            discharge_fet_drive_o <= 1'b0;
            charge_fet_drive_o <= 1'b0;
        end else if (idle_q2_r && seq_st_r == cep_pkg::SEQ_IDLE) begin
            discharge_fet_drive_o <= ~mem_par_err;
            charge_fet_drive_o <= ~mem_par_err;
        end
    end
endmodule

// ---- tb/cep_ctrl_monitor.sv ----
// Port-level checker for the configuration store controller
`timescale 1ns/1ps
module cep_ctrl_monitor (
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Serial port and commit pin
    input wire logic serial_port_select_pin_i,
    input wire logic serial_clock_line_i,
    input wire logic serial_data_line_o,
    input wire logic serial_data_line_oe_o,
    input wire logic nv_commit_pin_i,
    // Power path drives
    input wire logic discharge_fet_drive_o,
    input wire logic charge_fet_drive_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    // Store is unknown until a commit, so pairing and turn-on of the drives are judged only later
    logic commit_q_r = 1'b0;
    logic [5:0] since_r = 6'h00;
    logic settled;
    assign settled = since_r == 6'h3f;
    always_ff @(posedge clk_i) begin
        commit_q_r <= nv_commit_pin_i;
        if (commit_q_r && !nv_commit_pin_i) begin
            since_r <= 6'h01;
        end else if (since_r != 6'h00 && !settled) begin
            since_r <= since_r + 6'h01;
        end
    end
    sequence s_held;
        serial_data_line_oe_o [*5];
    endsequence
    sequence s_drives_on;
        ##[1:40] (discharge_fet_drive_o && charge_fet_drive_o);
    endsequence
    reset_quiet_a: assert property ($rose(nrst_i) |->
        !serial_data_line_oe_o && !discharge_fet_drive_o
        && !charge_fet_drive_o)
        else $error("outputs active right after reset");
    select_idle_a: assert property (
        !serial_port_select_pin_i [*3] |-> !serial_data_line_oe_o)
        else $error("data line driven while deselected");
    open_drain_a: assert property (
        serial_data_line_oe_o |-> !serial_data_line_o)
        else $error("data line driven high");
    oe_after_fall_a: assert property (
        $changed(serial_data_line_oe_o) && serial_port_select_pin_i
        && $past(serial_port_select_pin_i) |-> !serial_clock_line_i
        && ($past(serial_clock_line_i) || $past(serial_clock_line_i, 2)
        || $past(serial_clock_line_i, 3)))
        else $error("data line changed away from a clock fall");
    ack_hold_a: assert property ($rose(serial_data_line_oe_o) |-> s_held)
        else $error("data line pull too short");
    fet_pair_a: assert property (settled |->
        discharge_fet_drive_o == charge_fet_drive_o)
        else $error("drives differ");
    fet_load_a: assert property ($rose(nrst_i) && settled |-> s_drives_on)
        else $error("drives not on after reload");
    fet_hold_a: assert property (
        discharge_fet_drive_o && charge_fet_drive_o && settled
        |=> discharge_fet_drive_o && charge_fet_drive_o)
        else $error("drives dropped with consistent store");
endmodule

bind cep_ctrl cep_ctrl_monitor u_mon (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .serial_port_select_pin_i(serial_port_select_pin_i),
    .serial_clock_line_i(serial_clock_line_i),
    .serial_data_line_o(serial_data_line_o),
    .serial_data_line_oe_o(serial_data_line_oe_o),
    .nv_commit_pin_i(nv_commit_pin_i),
    .discharge_fet_drive_o(discharge_fet_drive_o),
    .charge_fet_drive_o(charge_fet_drive_o)
);

// ---- tb/cep_i2c_host.sv ----
// Serial host model: clock, open-drain data line and commit pin
`timescale 1ns/1ps
module cep_i2c_host #(
    parameter logic [6:0] ADDR = cep_pkg::DEV_ADDR_DEF
) (
    // Clock
    input wire logic clk_i,
    // Device pull on the data line
    input wire logic dev_oe_i,
    // Wire levels and commit pin
    output logic scl_o,
    output logic sda_o,
    output logic commit_o
);
    logic pull_r;
    // Pull-up: low only while some party pulls
    assign sda_o = ~(pull_r | dev_oe_i);
    initial begin
        pull_r = 1'b0;
        scl_o = 1'b1;
        commit_o = 1'b0;
    end
    // Data moves one clock after the clock line, never with it
    task automatic hold(input logic scl, input logic pull);
        @(posedge clk_i);
        scl_o <= scl;
        @(posedge clk_i);
        pull_r <= pull;
        repeat (2) @(posedge clk_i);
    endtask
    task automatic start();
        hold(1'b0, 1'b0);
        hold(1'b1, 1'b0);
        hold(1'b1, 1'b1);
        hold(1'b0, 1'b1);
    endtask
    task automatic stop();
        hold(1'b0, 1'b1);
        hold(1'b1, 1'b1);
        hold(1'b1, 1'b0);
    endtask
    task automatic bit_io(input logic drv, output logic seen);
        hold(1'b0, ~drv);
        hold(1'b1, ~drv);
        seen = sda_o;
    endtask
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(b[i], s);
        bit_io(1'b1, s);
        ack = ~s;
    endtask
    task automatic wr(input logic [7:0] p, input logic [7:0] d,
                      output logic ok);
        logic a0, a1, a2;
        start();
        wbyte({ADDR, 1'b0}, a0);
        wbyte(p, a1);
        wbyte(d, a2);
        stop();
        ok = a0 & a1 & a2;
    endtask
    task automatic rd(input logic [7:0] p, output logic [7:0] d,
                      output logic ok);
        logic a0, a1, a2, s;
        start();
        wbyte({ADDR, 1'b0}, a0);
        wbyte(p, a1);
        start();
        wbyte({ADDR, 1'b1}, a2);
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(1'b1, s);
        stop();
        ok = a0 & a1 & a2;
    endtask
    // High then low, then room for the row writes
    task automatic commit();
        pulse();
        repeat (40) @(posedge clk_i);
    endtask
    // Bare pulse, returns at the edge that lowers the pin
    task automatic pulse();
        @(posedge clk_i);
        commit_o <= 1'b1;
        repeat (4) @(posedge clk_i);
        commit_o <= 1'b0;
    endtask
endmodule

// ---- tb/cep_ctrl_test.sv ----
// Self-checking bench for the configuration store controller
`timescale 1ns/1ps
module cep_ctrl_test;
    logic clk_i;
    logic nrst_i;
    logic sel;
    logic scl;
    logic sda;
    logic commit;
    logic sda_o;
    logic sda_oe;
    logic discharge_fet_drive;
    logic charge_fet_drive;
    int n_errors = 0;
    int n_compared = 0;
    logic [7:0] stored [1:10];

    cep_ctrl uut (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .serial_port_select_pin_i(sel),
        .serial_clock_line_i(scl),
        .serial_data_line_i(sda),
        .serial_data_line_o(sda_o),
        .serial_data_line_oe_o(sda_oe),
        .nv_commit_pin_i(commit),
        .discharge_fet_drive_o(discharge_fet_drive),
        .charge_fet_drive_o(charge_fet_drive)
    );
    cep_i2c_host host (.clk_i(clk_i), .dev_oe_i(sda_oe), .scl_o(scl),
                       .sda_o(sda), .commit_o(commit));

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", what, exp, got);
            n_errors++;
        end
    endtask
    task automatic results();
        if (n_errors == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic put(input logic [7:0] p, input logic [7:0] d);
        logic ok;
        host.wr(p, d, ok);
        chk("write ack", 8'h01, {7'h00, ok});
    endtask
    task automatic get(input logic [7:0] p, input logic [7:0] e);
        logic ok;
        logic [7:0] d;
        host.rd(p, d, ok);
        chk("read ack", 8'h01, {7'h00, ok});
        chk("read data", e, d);
    endtask
    task automatic fets_on();
        int i;
        for (i = 0; i < 60 && !(discharge_fet_drive === 1'b1 && charge_fet_drive === 1'b1); i++) begin
            @(posedge clk_i);
        end
        chk("fet drives", 8'h03, {6'h00, discharge_fet_drive, charge_fet_drive});
        if (i >= 60) results();
    endtask
    // Reset cut into a commit leaves rows and parity disagreeing
    task automatic t_torn();
        put(8'h03, 8'ha5);
        put(cep_pkg::REG_NV_PROGRAM_KEY, cep_pkg::KEY_UNLOCK);
        host.pulse();
        repeat (4) @(posedge clk_i);
        nrst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        nrst_i <= 1'b1;
        repeat (60) @(posedge clk_i);
        chk("fet drives torn", 8'h00, {6'h00, discharge_fet_drive, charge_fet_drive});
        put(cep_pkg::REG_NV_PROGRAM_KEY, cep_pkg::KEY_UNLOCK);
        host.commit();
        fets_on();
    endtask
    task automatic t_reset_state();
        get(cep_pkg::REG_NV_PROGRAM_KEY, cep_pkg::KEY_RESET);
        put(8'h0c, 8'h5a);
        get(8'h0c, cep_pkg::RDATA_UNMAPPED);
    endtask
    task automatic t_program();
        for (int i = 1; i <= 10; i++) begin
            stored[i] = 8'h30 + 8'(i);
            put(8'(i), stored[i]);
        end
        put(cep_pkg::REG_NV_PROGRAM_KEY, cep_pkg::KEY_UNLOCK);
        host.commit();
        put(cep_pkg::REG_NV_PROGRAM_KEY, cep_pkg::KEY_PREREAD);
        for (int i = 1; i <= 10; i++) get(8'(i), stored[i]);
        fets_on();
    endtask
    task automatic t_locked();
        put(8'h03, 8'ha5);
        host.commit();
        get(8'h03, stored[3]);
        put(cep_pkg::REG_NV_PROGRAM_KEY, cep_pkg::KEY_RESET);
        get(8'h03, 8'ha5);
        host.commit();
        put(cep_pkg::REG_NV_PROGRAM_KEY, cep_pkg::KEY_PREREAD);
        get(8'h03, stored[3]);
        fets_on();
    endtask
    task automatic t_retain();
        @(posedge clk_i);
        nrst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        nrst_i <= 1'b1;
        repeat (30) @(posedge clk_i);
        get(cep_pkg::REG_NV_PROGRAM_KEY, cep_pkg::KEY_RESET);
        for (int i = 1; i <= 10; i++) get(8'(i), stored[i]);
        fets_on();
    endtask
    task automatic t_select_low();
        logic ok;
        @(posedge clk_i);
        sel <= 1'b0;
        host.wr(cep_pkg::REG_NV_PROGRAM_KEY, cep_pkg::KEY_UNLOCK, ok);
        chk("ack deselected", 8'h00, {7'h00, ok});
        @(posedge clk_i);
        sel <= 1'b1;
        get(cep_pkg::REG_NV_PROGRAM_KEY, cep_pkg::KEY_RESET);
    endtask

    initial begin
        nrst_i = 1'b0;
        sel = 1'b1;
        repeat (3) @(posedge clk_i);
        nrst_i <= 1'b1;
        repeat (30) @(posedge clk_i);
        t_reset_state();
        t_program();
        t_locked();
        t_retain();
        t_select_low();
        t_torn();
        results();
    end
endmodule
